//--- rdavg_pkg.sv
package rdavg_pkg;

  // register byte offsets
  localparam logic [7:0] RDAVG_OFS_CTRL = 8'h00;
  localparam logic [7:0] RDAVG_OFS_CFG = 8'h04;
  localparam logic [7:0] RDAVG_OFS_PLC = 8'h08;
  localparam logic [7:0] RDAVG_OFS_DIGITS = 8'h0C;
  localparam logic [7:0] RDAVG_OFS_CMD = 8'h10;
  localparam logic [7:0] RDAVG_OFS_STATUS = 8'h14;
  localparam logic [7:0] RDAVG_OFS_MEAN = 8'h18;

  // ctrl fields
  localparam int RDAVG_CTRL_FILT_BIT = 0;
  localparam int RDAVG_CTRL_SPEED_LSB = 1;
  localparam int RDAVG_CTRL_LPF_BIT = 3;
  // cfg fields
  localparam int RDAVG_CFG_FUNC_LSB = 0;
  localparam int RDAVG_CFG_RANGE_LSB = 4;
  localparam int RDAVG_CFG_CHAN_BIT = 8;
  // digits command fields
  localparam int RDAVG_DIG_OP_LSB = 8;
  // cmd fields
  localparam int RDAVG_CMD_PRESET_BIT = 0;
  localparam int RDAVG_CMD_IFRST_BIT = 1;

  // window lengths in readings
  localparam logic [6:0] RDAVG_LEN_FAST = 7'h0A;
  localparam logic [6:0] RDAVG_LEN_MED = 7'h32;
  localparam logic [6:0] RDAVG_LEN_SLOW = 7'h64;
  localparam int RDAVG_DEPTH = 100;

  // readings are in ppm of range: full scale is 1000000 counts
  localparam logic [11:0] RDAVG_THR_LOW_FAST = 12'h190;
  localparam logic [11:0] RDAVG_THR_LOW_MED = 12'h2BC;
  localparam logic [11:0] RDAVG_THR_LOW_SLOW = 12'h7D0;
  localparam logic [11:0] RDAVG_THR_FAST = 12'h064;
  localparam logic [11:0] RDAVG_THR_MED = 12'h12C;
  localparam logic [11:0] RDAVG_THR_SLOW = 12'h3E8;

  // integration time codes: 0.02,0.2,1,2,10,20,100,200 cycles
  localparam logic [2:0] RDAVG_PLC_0P02 = 3'h0;
  localparam logic [2:0] RDAVG_PLC_0P2 = 3'h1;
  localparam logic [2:0] RDAVG_PLC_1 = 3'h2;
  localparam logic [2:0] RDAVG_PLC_10 = 3'h4;
  localparam logic [2:0] RDAVG_PLC_20 = 3'h5;
  localparam logic [2:0] RDAVG_PLC_RST = RDAVG_PLC_10;
  localparam int RDAVG_NFUNC = 8;

  // resolution codes: 4.5, 5.5, 6.5, 7.5 digits
  localparam logic [1:0] RDAVG_RES_4H = 2'h0;
  localparam logic [1:0] RDAVG_RES_5H = 2'h1;
  localparam logic [1:0] RDAVG_RES_6H = 2'h2;
  localparam logic [1:0] RDAVG_RES_7H = 2'h3;
  localparam logic [1:0] RDAVG_RES_RST = RDAVG_RES_6H;

  // voltage ranges; code 0 is the lowest range
  localparam logic [3:0] RDAVG_RNG_1MV = 4'h0;
  localparam logic [3:0] RDAVG_RNG_100MV = 4'h2;

  typedef enum logic [1:0] {
    RDAVG_SPD_FAST, RDAVG_SPD_MED, RDAVG_SPD_SLOW, RDAVG_SPD_SLOW2
  } rdavg_speed_t;

  typedef enum logic [2:0] {
    RDAVG_FN_DCV, RDAVG_FN_RATIO, RDAVG_FN_DIFF, RDAVG_FN_RES2W,
    RDAVG_FN_RES4W, RDAVG_FN_TEMP_TC, RDAVG_FN_TEMP_RTD, RDAVG_FN_TEMP_THM
  } rdavg_func_t;

  typedef enum logic [1:0] {
    RDAVG_DOP_SELECT, RDAVG_DOP_UP, RDAVG_DOP_DOWN, RDAVG_DOP_NONE
  } rdavg_dop_t;

  typedef struct packed {
    logic chan;
    logic [3:0] range;
    rdavg_func_t func;
  } rdavg_cfg_t;

  typedef struct packed {
    logic valid;
    logic signed [23:0] data;
  } rdavg_result_t;

endpackage

//--- rdavg_window.sv
`timescale 1ns/10ps
`default_nettype none
module rdavg_window import rdavg_pkg::*; (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // control
  input wire logic clear,
  input wire logic push,
  input wire logic [6:0] win_len,
  input wire logic signed [23:0] din,
  // running totals after this cycle
  output logic signed [30:0] sum_next,
  output logic [6:0] cnt_next
);

  logic signed [23:0] mem [0:RDAVG_DEPTH-1];
  logic [6:0] wp_reg;
  logic [6:0] old_idx;
  logic signed [30:0] sum_reg;
  logic [6:0] cnt_reg;
  logic signed [30:0] din_ext;

  assign din_ext = {{7{din[23]}}, din};

  // oldest reading still inside the window, len entries behind the pointer
  always_comb begin
    if (wp_reg >= win_len) begin
      old_idx = wp_reg - win_len;
    end else begin
      old_idx = 7'(wp_reg + 7'h64 - win_len);
    end
  end

  always_comb begin
    sum_next = sum_reg;
    cnt_next = cnt_reg;
    if (clear) begin
      sum_next = push ? din_ext : 31'h0;
      cnt_next = push ? 7'h01 : 7'h00;
    end else if (push) begin
      if (cnt_reg < win_len) begin
        sum_next = sum_reg + din_ext;
        cnt_next = 7'(cnt_reg + 7'h01);
      end else begin
        // stale entries beyond cnt are never subtracted
        sum_next = sum_reg + din_ext - {{7{mem[old_idx][23]}}, mem[old_idx]};
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sum_reg <= 31'h0;
      cnt_reg <= 7'h00;
      wp_reg <= 7'h00;
    end else begin
      sum_reg <= sum_next;
      cnt_reg <= cnt_next;
      if (push) begin
        wp_reg <= (wp_reg == 7'h63) ? 7'h00 : 7'(wp_reg + 7'h01);
      end
    end
  end

  // data store, no reset needed: the count guards every read
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wp_reg] <= din;
    end
  end

endmodule
`default_nettype wire

//--- rdavg_rescap.sv
`timescale 1ns/10ps
`default_nettype none
module rdavg_rescap import rdavg_pkg::*; (
  // settings
  input wire logic [2:0] plc_code,
  input wire logic filt_on,
  // highest resolution allowed
  output logic [1:0] cap
);

  always_comb begin
    if (filt_on) begin
      if (plc_code == RDAVG_PLC_0P02) begin
        cap = RDAVG_RES_5H;
      end else if (plc_code == RDAVG_PLC_0P2) begin
        cap = RDAVG_RES_6H;
      end else begin
        cap = RDAVG_RES_7H;
      end
    end else begin
      if (plc_code == RDAVG_PLC_0P02) begin
        cap = RDAVG_RES_4H;
      end else if (plc_code == RDAVG_PLC_0P2) begin
        cap = RDAVG_RES_5H;
      end else if (plc_code < RDAVG_PLC_20) begin
        cap = RDAVG_RES_6H;
      end else begin
        cap = RDAVG_RES_7H;
      end
    end
  end

endmodule
`default_nettype wire

//--- rdavg_top.sv
`timescale 1ns/10ps
`default_nettype none
module rdavg_top import rdavg_pkg::*; (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // readings from the converter
  input wire logic rdg_valid,
  input wire logic signed [23:0] rdg_data,
  // filtered results and status
  output rdavg_result_t result,
  output logic settling,
  output logic lpf_on,
  output logic [1:0] digits_shown,
  output logic [2:0] plc_active
);

  ////////////////////////////////////////////////////////////////////////////
  // bus decode

  logic acc_start;
  logic acc_done;
  logic wr_en;
  logic map_hit;
  logic wr_ctrl, wr_cfg, wr_plc, wr_dig, wr_cmd, wr_stat;
  logic soft_rst;
  logic preset;
  logic plc_bad;

  assign acc_start = psel & penable & ~pready;
  assign acc_done = psel & penable & pready;
  assign wr_en = acc_done & pwrite;
  assign wr_ctrl = wr_en & (paddr == RDAVG_OFS_CTRL);
  assign wr_cfg = wr_en & (paddr == RDAVG_OFS_CFG);
  assign wr_plc = wr_en & (paddr == RDAVG_OFS_PLC);
  assign wr_dig = wr_en & (paddr == RDAVG_OFS_DIGITS);
  assign wr_cmd = wr_en & (paddr == RDAVG_OFS_CMD);
  assign wr_stat = wr_en & (paddr == RDAVG_OFS_STATUS);
  assign soft_rst = wr_cmd & pwdata[RDAVG_CMD_IFRST_BIT];
  assign preset = wr_cmd & pwdata[RDAVG_CMD_PRESET_BIT];
  // codes 8..15 are not integration times
  assign plc_bad = pwdata[3];

  always_comb begin
    if (paddr == RDAVG_OFS_CTRL || paddr == RDAVG_OFS_CFG ||
        paddr == RDAVG_OFS_PLC || paddr == RDAVG_OFS_DIGITS ||
        paddr == RDAVG_OFS_CMD || paddr == RDAVG_OFS_STATUS ||
        paddr == RDAVG_OFS_MEAN) begin
      map_hit = 1'b1;
    end else begin
      map_hit = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers

  logic filt_en_reg;
  rdavg_speed_t speed_reg;
  logic lpf_req_reg;
  rdavg_cfg_t cfg_reg;
  logic [1:0] res_reg;
  logic err_reg;
  rdavg_dop_t dop;
  logic [1:0] dig_val;
  logic [2:0] plc_cur;
  logic [1:0] cap;
  logic [2:0] dig_plc;

  assign dop = rdavg_dop_t'(pwdata[RDAVG_DIG_OP_LSB +: 2]);
  assign dig_val = pwdata[1:0];

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      filt_en_reg <= 1'b0;
      speed_reg <= RDAVG_SPD_FAST;
      lpf_req_reg <= 1'b0;
    end else if (soft_rst || preset) begin
      filt_en_reg <= 1'b0;
    end else if (wr_ctrl) begin
      filt_en_reg <= pwdata[RDAVG_CTRL_FILT_BIT];
      speed_reg <= rdavg_speed_t'(pwdata[RDAVG_CTRL_SPEED_LSB +: 2]);
      lpf_req_reg <= pwdata[RDAVG_CTRL_LPF_BIT];
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_reg <= '0;
    end else if (wr_cfg) begin
      cfg_reg.func <= rdavg_func_t'(pwdata[RDAVG_CFG_FUNC_LSB +: 3]);
      cfg_reg.range <= pwdata[RDAVG_CFG_RANGE_LSB +: 4];
      cfg_reg.chan <= pwdata[RDAVG_CFG_CHAN_BIT];
    end
  end

  // integration time that a digit selection implies
  always_comb begin
    case (dig_val)
      RDAVG_RES_4H: dig_plc = RDAVG_PLC_0P02;
      RDAVG_RES_5H: dig_plc = RDAVG_PLC_0P2;
      RDAVG_RES_6H: dig_plc = RDAVG_PLC_10;
      default: dig_plc = RDAVG_PLC_20;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // integration time, one setting per function

  logic [2:0] plc_mem [0:RDAVG_NFUNC-1];

  genvar fi;
  generate
    for (fi = 0; fi < RDAVG_NFUNC; fi++) begin : g_plc
      always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
          plc_mem[fi] <= RDAVG_PLC_RST;
        end else if (soft_rst) begin
          plc_mem[fi] <= RDAVG_PLC_RST;
        end else if (cfg_reg.func == 3'(fi)) begin
          if (wr_plc && !plc_bad) begin
            plc_mem[fi] <= pwdata[2:0];
          end else if (wr_dig && dop == RDAVG_DOP_SELECT) begin
            plc_mem[fi] <= dig_plc;
          end
        end
      end
    end
  endgenerate

  assign plc_cur = plc_mem[cfg_reg.func];

  // sticky reject flag, a new reject wins over the clear
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      err_reg <= 1'b0;
    end else if (wr_plc && plc_bad) begin
      err_reg <= 1'b1;
    end else if (wr_stat && pwdata[0]) begin
      err_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // display resolution

  rdavg_rescap u_rescap (
    .plc_code(plc_cur),
    .filt_on(filt_en_reg),
    .cap(cap)
  );

  // res_reg is the user's choice; the shown value is clipped to the cap
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      res_reg <= RDAVG_RES_RST;
    end else if (soft_rst || preset) begin
      res_reg <= RDAVG_RES_RST;
    end else if (wr_dig) begin
      case (dop)
        RDAVG_DOP_SELECT: res_reg <= dig_val;
        RDAVG_DOP_UP: begin
          if (res_reg < cap) begin
            res_reg <= 2'(res_reg + 2'h1);
          end
        end
        RDAVG_DOP_DOWN: begin
          if (res_reg > cap) begin
            res_reg <= (cap == RDAVG_RES_4H) ? cap : 2'(cap - 2'h1);
          end else if (res_reg != RDAVG_RES_4H) begin
            res_reg <= 2'(res_reg - 2'h1);
          end
        end
        default: res_reg <= res_reg;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      digits_shown <= RDAVG_RES_RST;
    end else begin
      digits_shown <= (res_reg > cap) ? cap : res_reg;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      plc_active <= RDAVG_PLC_RST;
    end else begin
      plc_active <= plc_cur;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // analog low-pass permission

  logic volt_fn;
  logic lpf_ok;

  assign volt_fn = cfg_reg.func == RDAVG_FN_DCV ||
                   cfg_reg.func == RDAVG_FN_RATIO ||
                   cfg_reg.func == RDAVG_FN_DIFF;
  // resistance functions fall in neither branch, so they never pass
  assign lpf_ok = (volt_fn && cfg_reg.range <= RDAVG_RNG_100MV) ||
                  cfg_reg.func == RDAVG_FN_TEMP_TC;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lpf_on <= 1'b0;
    end else begin
      lpf_on <= lpf_req_reg & lpf_ok;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // averaging window

  logic [6:0] win_len;
  logic [11:0] thr;
  logic [15:0] key, key_prev_reg;
  logic cfg_change;
  logic signed [24:0] dev;
  logic [24:0] dev_abs;
  logic [6:0] cnt_reg;
  logic far_off;
  logic win_clear;
  logic push;
  logic signed [30:0] sum_next;
  logic [6:0] cnt_next;
  logic signed [30:0] quot;

  always_comb begin
    case (speed_reg)
      RDAVG_SPD_FAST: win_len = RDAVG_LEN_FAST;
      RDAVG_SPD_MED: win_len = RDAVG_LEN_MED;
      default: win_len = RDAVG_LEN_SLOW;
    endcase
  end

  always_comb begin
    if (cfg_reg.range == RDAVG_RNG_1MV) begin
      case (speed_reg)
        RDAVG_SPD_FAST: thr = RDAVG_THR_LOW_FAST;
        RDAVG_SPD_MED: thr = RDAVG_THR_LOW_MED;
        default: thr = RDAVG_THR_LOW_SLOW;
      endcase
    end else begin
      case (speed_reg)
        RDAVG_SPD_FAST: thr = RDAVG_THR_FAST;
        RDAVG_SPD_MED: thr = RDAVG_THR_MED;
        default: thr = RDAVG_THR_SLOW;
      endcase
    end
  end

  // both bits of speed fit in the 16-bit key, so any speed change, fast to slow included, gives a fresh count
  assign key = {2'(speed_reg), cfg_reg, plc_cur, 2'h0, filt_en_reg};
  assign cfg_change = key != key_prev_reg;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      key_prev_reg <= 16'h0000;
    end else begin
      key_prev_reg <= key;
    end
  end

  // deviation from the mean last reported
  assign dev = 25'(rdg_data) - 25'(result.data);
  assign dev_abs = dev[24] ? 25'(-dev) : 25'(dev);
  assign far_off = cnt_reg != 7'h00 && dev_abs > 25'(thr);

  assign push = rdg_valid & filt_en_reg;
  // a far-off reading opens the new count rather than being dropped
  assign win_clear = ~filt_en_reg | cfg_change | (rdg_valid & far_off);

  rdavg_window u_window (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .clear(win_clear),
    .push(push),
    .win_len(win_len),
    .din(rdg_data),
    .sum_next(sum_next),
    .cnt_next(cnt_next)
  );

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt_reg <= 7'h00;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  // divide by the count held, not by the window length
  assign quot = (cnt_next == 7'h00) ? 31'h0 :
                sum_next / $signed({24'h000000, cnt_next});

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      result <= '0;
    end else begin
      result.valid <= rdg_valid;
      if (rdg_valid) begin
        result.data <= filt_en_reg ? quot[23:0] : rdg_data;
      end
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      settling <= 1'b0;
    end else begin
      settling <= filt_en_reg & (cnt_next < win_len);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb answer: one wait state, registered read data

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= acc_start;
      pslverr <= acc_start & (~map_hit |
                 (pwrite & paddr == RDAVG_OFS_PLC & pwdata[3]));
      if (acc_start && !pwrite) begin
        if (paddr == RDAVG_OFS_CTRL) begin
          prdata <= {28'h0, lpf_req_reg, 2'(speed_reg), filt_en_reg};
        end else if (paddr == RDAVG_OFS_CFG) begin
          prdata <= {23'h0, cfg_reg.chan, cfg_reg.range, 1'b0,
                     3'(cfg_reg.func)};
        end else if (paddr == RDAVG_OFS_PLC) begin
          prdata <= {29'h0, plc_cur};
        end else if (paddr == RDAVG_OFS_DIGITS) begin
          prdata <= {26'h0, cap, 2'h0, res_reg};
        end else if (paddr == RDAVG_OFS_STATUS) begin
          prdata <= {17'h0, cnt_reg, 3'h0, digits_shown, lpf_on, settling,
                     err_reg};
        end else if (paddr == RDAVG_OFS_MEAN) begin
          prdata <= {{8{result.data[23]}}, result.data};
        end else begin
          prdata <= 32'h00000000;
        end
      end
    end
  end

endmodule
`default_nettype wire

//--- rdavg_checker.sv
`timescale 1ns/10ps
`default_nettype none
module rdavg_checker import rdavg_pkg::*; (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // apb handshake
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // readings and results
  input wire logic rdg_valid,
  input wire rdavg_result_t result,
  input wire logic settling,
  input wire logic [1:0] digits_shown,
  input wire logic [2:0] plc_active
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  AST_RESULT_STROBE: assert property (rdg_valid |=> result.valid)
    else $error("no result one cycle after a reading");
  AST_IDLE_HOLDS: assert property (
    !rdg_valid |=> !result.valid && $stable(result.data))
    else $error("result moved without a reading");
  AST_RESET_STATE: assert property (
    $fell(sys_rst) |-> digits_shown == RDAVG_RES_RST &&
    plc_active == RDAVG_PLC_RST)
    else $error("wrong resolution or integration after reset");
  AST_CAP_FASTEST: assert property (
    $stable(plc_active) && plc_active == RDAVG_PLC_0P02 |->
    digits_shown <= RDAVG_RES_5H)
    else $error("resolution above cap at shortest integration");
  AST_CAP_SHORT: assert property (
    $stable(plc_active) && plc_active == RDAVG_PLC_0P2 |->
    digits_shown <= RDAVG_RES_6H)
    else $error("resolution above cap at short integration");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  AST_READY_LATENCY: assert property (psel && penable && !pready |=> pready)
    else $error("ready late");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("error without ready");

  COV_SETTLING: cover property (rdg_valid ##1 settling);
  COV_SETTLED: cover property ($fell(settling));
  COV_REFUSED: cover property (pslverr);
endmodule

bind rdavg_top rdavg_checker u_chk (.core_clk(core_clk), .sys_rst(sys_rst),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .rdg_valid(rdg_valid), .result(result), .settling(settling),
  .digits_shown(digits_shown), .plc_active(plc_active));
`default_nettype wire

//--- rdavg_adc_model.sv
`timescale 1ns/10ps
`default_nettype none
module rdavg_adc_model (
  // clock
  input wire logic core_clk,
  // trigger and input level from the bench
  input wire logic trig,
  input wire logic signed [23:0] level,
  // reading stream
  output logic rdg_valid,
  output logic signed [23:0] rdg_data
);
  initial begin
    rdg_valid = 1'h0;
    rdg_data = 24'h0;
  end
  // one reading per trigger; data is scrambled outside valid cycles
  always @(posedge core_clk) begin
    rdg_valid <= trig;
    rdg_data <= trig ? level : ~rdg_data;
  end
endmodule
`default_nettype wire

//--- rdavg_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
module rdavg_top_tb import rdavg_pkg::*;;
  logic core_clk, sys_rst, psel, penable, pwrite, pready, pslverr, trig;
  logic rdg_valid, settling, lpf_on, filt, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] digits_shown;
  logic [2:0] plc_active;
  logic signed [23:0] rdg_data, level;
  rdavg_result_t result;
  int error_cnt, checks, seed, len, thr, last, rg;
  int win[$], exp_d[$];
  logic exp_s[$];
  logic [8:0] lcfg [6] = '{9'h000, 9'h020, 9'h030, 9'h003, 9'h004, 9'h055};
  logic [5:0] lexp = 6'h23;

  rdavg_top uut (.core_clk(core_clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rdg_valid(rdg_valid), .rdg_data(rdg_data), .result(result),
    .settling(settling), .lpf_on(lpf_on), .digits_shown(digits_shown),
    .plc_active(plc_active));
  rdavg_adc_model adc (.core_clk(core_clk), .trig(trig), .level(level),
    .rdg_valid(rdg_valid), .rdg_data(rdg_data));

  initial begin
    core_clk = 1'h0;
    forever #2 core_clk = ~core_clk;
  end

  function automatic int rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task chk(logic [31:0] got, logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task summarize();
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task apb(logic wr, logic [7:0] a, logic [31:0] d);
    int n;
    @(posedge core_clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (!pready && n < 20);
    if (pready !== 1'h1) begin
      error_cnt++;
      summarize();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    // let registered status catch up before it is looked at
    repeat (3) @(posedge core_clk);
  endtask

  // reference window: restart on a jump, slide at the selected length
  task send(int x);
    int s;
    if (filt && win.size() > 0 && (x - last > thr || last - x > thr))
      win.delete();
    win.push_back(x);
    if (win.size() > len)
      void'(win.pop_front());
    s = 0;
    foreach (win[i]) s += win[i];
    last = filt ? s / win.size() : x;
    exp_d.push_back(last);
    exp_s.push_back(filt && win.size() < len);
    level <= 24'(x);
    trig <= 1'h1;
    @(posedge core_clk);
  endtask

  always @(negedge core_clk) begin
    if (result.valid === 1'h1) begin
      if (exp_d.size() == 0) begin
        chk(1, 0);
      end else begin
        chk(result.data, exp_d.pop_front());
        chk(settling, exp_s.pop_front());
      end
    end
  end

  initial begin
    repeat (100000) @(posedge core_clk);
    error_cnt++;
    summarize();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_rst = 1'h1;
    {psel, penable, pwrite, paddr, pwdata, trig, level, filt} = '0;
    seed = 93155;
    len = 10;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'h0;
    apb(1'h0, RDAVG_OFS_PLC, 32'h0);
    chk(rd, 32'(RDAVG_PLC_RST));
    chk(digits_shown, RDAVG_RES_RST);
    apb(1'h0, 8'h1C, 32'h0);
    chk({err, rd[30:0]}, 32'h80000000);
    apb(1'h1, RDAVG_OFS_PLC, 32'h8);
    chk(err, 1);
    apb(1'h0, RDAVG_OFS_STATUS, 32'h0);
    chk(rd, 32'h00000011);
    apb(1'h1, RDAVG_OFS_PLC, 32'h3);
    chk({err, plc_active}, 3);
    apb(1'h1, RDAVG_OFS_CFG, 32'h1);
    chk(plc_active, RDAVG_PLC_RST);
    apb(1'h1, RDAVG_OFS_CFG, 32'h0);
    chk(plc_active, 3);
    for (int v = 0; v < 4; v++) begin
      apb(1'h1, RDAVG_OFS_DIGITS, 32'(v));
      chk(plc_active, (v > 1) ? v + 2 : v);
      chk(digits_shown, v);
    end
    for (int i = 0; i < 4; i++) begin
      apb(1'h1, RDAVG_OFS_DIGITS, 32'h200);
      chk({plc_active, digits_shown},
          {3'h5, 2'((i < 3) ? 2 - i : 0)});
    end
    apb(1'h1, RDAVG_OFS_DIGITS, 32'h0);
    apb(1'h1, RDAVG_OFS_DIGITS, 32'h100);
    chk(digits_shown, RDAVG_RES_4H);
    apb(1'h1, RDAVG_OFS_CTRL, 32'h1);
    for (int i = 0; i < 2; i++) begin
      apb(1'h1, RDAVG_OFS_DIGITS, 32'h100);
      chk(digits_shown, RDAVG_RES_5H);
    end
    apb(1'h1, RDAVG_OFS_DIGITS, 32'h3);
    apb(1'h1, RDAVG_OFS_CMD, 32'h1);
    chk({plc_active, digits_shown}, {3'h5, RDAVG_RES_RST});
    apb(1'h0, RDAVG_OFS_CTRL, 32'h0);
    chk(rd[0], 0);
    apb(1'h1, RDAVG_OFS_CTRL, 32'h1);
    apb(1'h1, RDAVG_OFS_CMD, 32'h2);
    chk(plc_active, RDAVG_PLC_RST);
    apb(1'h0, RDAVG_OFS_CTRL, 32'h0);
    chk(rd[0], 0);
    apb(1'h1, RDAVG_OFS_CTRL, 32'h8);
    for (int i = 0; i < 6; i++) begin
      apb(1'h1, RDAVG_OFS_CFG, 32'(lcfg[i]));
      chk(lpf_on, lexp[i]);
    end
    send(1234);
    send(77);
    trig <= 1'h0;
    filt = 1'h1;
    for (int sp = 0; sp < 3; sp++) begin
      for (int r = 0; r < 2; r++) begin
        rg = r ? 0 : 3;
        len = sp == 0 ? RDAVG_LEN_FAST :
              sp == 1 ? RDAVG_LEN_MED : RDAVG_LEN_SLOW;
        if (rg == 0)
          thr = sp == 0 ? 400 : sp == 1 ? 700 : 2000;
        else
          thr = sp == 0 ? 100 : sp == 1 ? 300 : 1000;
        apb(1'h1, RDAVG_OFS_CFG, 32'(rg << 4));
        apb(1'h1, RDAVG_OFS_CTRL, 32'(sp * 2 + 1));
        win.delete();
        for (int i = 0; i <= len; i++) begin
          send(1000 + (rnd() & 15));
          if (rnd() & 1) begin
            trig <= 1'h0;
            @(posedge core_clk);
          end
        end
        send(last + thr);
        send(last + thr + 1);
        trig <= 1'h0;
        repeat (3) @(posedge core_clk);
      end
    end
    repeat (5) @(posedge core_clk);
    chk(exp_d.size(), 0);
    summarize();
  end
endmodule
`default_nettype wire
